//--- design/egress_vlan_tag_editor.sv
// egress vlan tag decision, drop counters and interrupt sources
`timescale 1ns/10ps
`include "egress_tag_cfg.svh"
module egress_vlan_tag_editor #(
    parameter int CNT_W = 32
) (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 reset_n,
    // frame descriptor from the queues
    input  wire logic                 frame_valid,
    output logic                      frame_ready,
    input  wire logic [1:0]           frame_kind,
    input  wire logic [1:0]           ingress_port,
    input  wire logic [1:0]           egress_port,
    input  wire logic [`VID_W-1:0]    rx_vlan_identifier,
    input  wire logic [`PRIO_W-1:0]   rx_prio,
    input  wire logic [`PRIO_W-1:0]   ingress_prio,
    input  wire logic [2:0]           untag_by_default,
    input  wire logic [2:0]           untag_by_rx,
    // configuration
    input  wire logic [3*`CFG_PORT_W-1:0] egress_port_tag_config,
    input  wire logic [`DEF_W-1:0]    port0_default_vlan_prio,
    input  wire logic [`DEF_W-1:0]    port1_default_vlan_prio,
    input  wire logic [`DEF_W-1:0]    port2_default_vlan_prio,
    // edit instruction to the transmit mac
    output logic                      edit_valid,
    input  wire logic                 edit_ready,
    output logic [2:0]                edit_action,
    output logic [`VID_W-1:0]         edit_vlan_identifier,
    output logic [`PRIO_W-1:0]        edit_prio,
    output logic [1:0]                edit_port,
    output logic                      fcs_regen,
    // drop events per ingress port
    input  wire logic [2:0]           buffer_drop,
    input  wire logic [2:0]           rate_drop,
    input  wire logic                 count_clear,
    // drop counters
    output logic [CNT_W-1:0]          port0_total_drop_count,
    output logic [CNT_W-1:0]          port1_total_drop_count,
    output logic [CNT_W-1:0]          port2_total_drop_count,
    output logic [CNT_W-1:0]          port0_rate_drop_count,
    output logic [CNT_W-1:0]          port1_rate_drop_count,
    output logic [CNT_W-1:0]          port2_rate_drop_count,
    // interrupt sources
    input  wire logic [2:0]           irq_mask,
    output logic [2:0]                irq_sources
);

    initial begin
        if (CNT_W < 1 || CNT_W > 64) begin
            $error("CNT_W must lie in 1..64");
        end
    end

    // -------------------------------------------------------------------
    // lookup helpers
    // -------------------------------------------------------------------

    // config bits of one egress port, port 3 reads as dumb
    function automatic logic [`CFG_PORT_W-1:0] port_cfg(
        input logic [3*`CFG_PORT_W-1:0] all,
        input logic [1:0]               p
    );
        case (p)
            2'h0: port_cfg = all[0 +: `CFG_PORT_W];
            2'h1: port_cfg = all[`CFG_PORT_W +: `CFG_PORT_W];
            2'h2: port_cfg = all[2*`CFG_PORT_W +: `CFG_PORT_W];
            default: port_cfg = '0;
        endcase
    endfunction : port_cfg

    // default vid and priority of one port
    function automatic logic [`DEF_W-1:0] port_def(
        input logic [`DEF_W-1:0] d0,
        input logic [`DEF_W-1:0] d1,
        input logic [`DEF_W-1:0] d2,
        input logic [1:0]        p
    );
        case (p)
            2'h0: port_def = d0;
            2'h1: port_def = d1;
            2'h2: port_def = d2;
            default: port_def = '0;
        endcase
    endfunction : port_def

    // per-port untag bit of an instruction
    function automatic logic untag_bit(
        input logic [2:0] instr,
        input logic [1:0] p
    );
        untag_bit = (p == 2'h3) ? 1'b0 : instr[p];
    endfunction : untag_bit

    // -------------------------------------------------------------------
    // tag decision
    // -------------------------------------------------------------------
    logic [`CFG_PORT_W-1:0]            ecfg;
    egress_tag_pkg::port_type_t        etype;
    egress_tag_pkg::frame_kind_t       fkind;
    logic [`DEF_W-1:0]                 idef;
    logic [`DEF_W-1:0]                 edef;
    logic [`VID_W-1:0]                 sel_vid;
    logic [`PRIO_W-1:0]                sel_prio;
    logic                              untag_def;
    logic                              untag_rx;
    logic                              chg_vid;
    logic                              chg_prio;
    egress_tag_pkg::tag_action_t       dec_action;
    logic [`VID_W-1:0]                 dec_vid;
    logic [`PRIO_W-1:0]                dec_prio;

    // defaults and untag bits of the frame's ports
    assign ecfg      = port_cfg(egress_port_tag_config, egress_port);
    assign etype     = egress_tag_pkg::port_type_t'(
                           ecfg[`CFG_TYPE_LSB +: 2]);
    assign fkind     = egress_tag_pkg::frame_kind_t'(frame_kind);
    assign idef      = port_def(port0_default_vlan_prio,       // R14
                           port1_default_vlan_prio,
                           port2_default_vlan_prio, ingress_port);
    assign edef      = port_def(port0_default_vlan_prio,
                           port1_default_vlan_prio,
                           port2_default_vlan_prio, egress_port);
    assign untag_def = untag_bit(untag_by_default, egress_port); // R5
    assign untag_rx  = untag_bit(untag_by_rx, egress_port);      // R5
    assign chg_vid   = ecfg[`CFG_CHANGE_VID_BIT];
    assign chg_prio  = ecfg[`CFG_CHANGE_PRIO_BIT];

    // select bit set takes egress defaults, clear takes ingress values
    assign sel_vid  = ecfg[`CFG_SELECT_BIT]                     // R7
                    ? edef[`DEF_VID_LSB +: `VID_W]
                    : idef[`DEF_VID_LSB +: `VID_W];
    assign sel_prio = ecfg[`CFG_SELECT_BIT]                     // R7
                    ? edef[`DEF_PRIO_LSB +: `PRIO_W]
                    : ingress_prio;

    // action per egress type and frame kind
    always_comb begin
        dec_action = egress_tag_pkg::act_pass;
        dec_vid    = rx_vlan_identifier;
        dec_prio   = rx_prio;
        if (etype == egress_tag_pkg::port_cpu) begin
            if (fkind != egress_tag_pkg::kind_special) begin
                dec_action = egress_tag_pkg::act_host_tag;      // R4
            end
        end else if (fkind == egress_tag_pkg::kind_special) begin
            dec_action = egress_tag_pkg::act_strip;             // R2
        end else begin
            case (etype)
                egress_tag_pkg::port_dumb: begin
                    dec_action = egress_tag_pkg::act_pass;      // R1
                end
                egress_tag_pkg::port_access: begin
                    if (fkind != egress_tag_pkg::kind_untagged) begin
                        dec_action = egress_tag_pkg::act_strip; // R3
                    end
                end
                egress_tag_pkg::port_hybrid: begin
                    case (fkind)
                        egress_tag_pkg::kind_untagged: begin
                            if (ecfg[`CFG_INSERT_BIT] && !untag_def) begin
                                dec_action = egress_tag_pkg::act_insert; // R6
                                dec_vid    = sel_vid;           // R7
                                dec_prio   = sel_prio;          // R7
                            end
                        end
                        egress_tag_pkg::kind_priority: begin
                            if (untag_def) begin
                                dec_action = egress_tag_pkg::act_strip; // R8
                            end else begin
                                dec_action = egress_tag_pkg::act_rewrite;
                                dec_vid    = sel_vid;           // R9
                                if (chg_prio) begin
                                    dec_prio = sel_prio;        // R9
                                end
                            end
                        end
                        egress_tag_pkg::kind_normal: begin
                            if (untag_rx) begin
                                dec_action = egress_tag_pkg::act_strip; // R10
                            end else if (!ecfg[`CFG_CHANGE_TAG_BIT]) begin
                                dec_action = egress_tag_pkg::act_pass; // R11
                            end else if (!chg_vid && !chg_prio) begin
                                dec_action = egress_tag_pkg::act_pass; // R12
                            end else begin
                                dec_action = egress_tag_pkg::act_rewrite;
                                if (chg_vid) begin
                                    dec_vid = sel_vid;          // R13
                                end
                                if (chg_prio) begin
                                    dec_prio = sel_prio;        // R13
                                end
                            end
                        end
                        default: begin
                            dec_action = egress_tag_pkg::act_pass;
                        end
                    endcase
                end
                default: begin
                    dec_action = egress_tag_pkg::act_pass;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // edit buffer toward the transmit mac
    // -------------------------------------------------------------------
    localparam int EW = 3 + `VID_W + `PRIO_W + 2 + 1;

    logic          dec_fcs;
    logic [EW-1:0] push_word;
    logic [EW-1:0] pop_word;

    // any tag change needs a fresh frame check sequence
    assign dec_fcs   = (dec_action != egress_tag_pkg::act_pass);  // R18
    assign push_word = {dec_action, dec_vid, dec_prio, egress_port, dec_fcs};

    edit_buffer #(
        .WIDTH     (EW),
        .DEPTH     (2)
    ) u_buffer (
        .clock     (clock),
        .reset_n   (reset_n),
        .in_valid  (frame_valid),
        .in_ready  (frame_ready),
        .in_data   (push_word),
        .out_valid (edit_valid),
        .out_ready (edit_ready),
        .out_data  (pop_word)
    );

    // unpack the buffered instruction
    assign {edit_action, edit_vlan_identifier, edit_prio,
            edit_port, fcs_regen} = pop_word;

    // -------------------------------------------------------------------
    // drop counters
    // -------------------------------------------------------------------
    logic [CNT_W-1:0] total_q [3];
    logic [CNT_W-1:0] rate_q  [3];

    // event beats clear: a drop in the clear cycle counts as one
    function automatic logic [CNT_W-1:0] next_count(
        input logic [CNT_W-1:0] cur,
        input logic             hit,
        input logic             clr
    );
        if (hit) begin
            next_count = clr ? CNT_W'(1) : CNT_W'(cur + 1'b1);
        end else begin
            next_count = clr ? '0 : cur;
        end
    endfunction : next_count

    // total drops include rate drops
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 3; i++) begin
                total_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                total_q[i] <= next_count(total_q[i],              // R15
                    buffer_drop[i] | rate_drop[i], count_clear);
            end
        end
    end

    // rate-limit drops alone
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 3; i++) begin
                rate_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                rate_q[i] <= next_count(rate_q[i], rate_drop[i], // R16
                    count_clear);
            end
        end
    end

    assign port0_total_drop_count = total_q[0];
    assign port1_total_drop_count = total_q[1];
    assign port2_total_drop_count = total_q[2];
    assign port0_rate_drop_count  = rate_q[0];
    assign port1_rate_drop_count  = rate_q[1];
    assign port2_rate_drop_count  = rate_q[2];

    // -------------------------------------------------------------------
    // interrupt sources
    // -------------------------------------------------------------------

    // one masked pulse per port drop event
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_sources <= `IRQ_RESET;
        end else begin
            irq_sources <= (buffer_drop | rate_drop) & irq_mask; // R17
        end
    end

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    logic push_fire;
    assign push_fire = frame_valid & frame_ready;

    chk_dumb_pass: assert property (push_fire && etype == egress_tag_pkg::port_dumb // R1
        && fkind != egress_tag_pkg::kind_special
        |-> dec_action == egress_tag_pkg::act_pass && !dec_fcs)
        else $error("dumb port altered a tag");

    chk_special_strip: assert property (push_fire // R2
        && fkind == egress_tag_pkg::kind_special
        && etype != egress_tag_pkg::port_cpu
        |-> dec_action == egress_tag_pkg::act_strip)
        else $error("special tag not stripped");

    chk_access_strip: assert property (push_fire // R3
        && etype == egress_tag_pkg::port_access
        && fkind inside {egress_tag_pkg::kind_priority,
                         egress_tag_pkg::kind_normal}
        |-> dec_action == egress_tag_pkg::act_strip)
        else $error("access port kept a tag");

    chk_cpu_host_tag: assert property (push_fire // R4
        && etype == egress_tag_pkg::port_cpu
        && fkind == egress_tag_pkg::kind_untagged
        |-> dec_action == egress_tag_pkg::act_host_tag)
        else $error("cpu port frame lacks host tag");

    chk_hybrid_insert: assert property (push_fire // R6
        && etype == egress_tag_pkg::port_hybrid
        && fkind == egress_tag_pkg::kind_untagged
        |-> (dec_action == egress_tag_pkg::act_insert)
            == (ecfg[`CFG_INSERT_BIT] && !untag_def))
        else $error("hybrid insert decision wrong");

    chk_prio_rewrite: assert property (push_fire // R9
        && etype == egress_tag_pkg::port_hybrid
        && fkind == egress_tag_pkg::kind_priority && !untag_def
        |-> dec_action == egress_tag_pkg::act_rewrite && dec_vid == sel_vid
            && dec_prio == (chg_prio ? sel_prio : rx_prio))
        else $error("priority tag rewrite wrong");

    chk_normal_keep: assert property (push_fire // R12
        && etype == egress_tag_pkg::port_hybrid
        && fkind == egress_tag_pkg::kind_normal && !untag_rx
        && !(chg_vid || chg_prio)
        |-> dec_action == egress_tag_pkg::act_pass)
        else $error("normal tag changed without change bits");

    chk_edit_order: assert property (push_fire && !edit_valid // R18
        |=> edit_valid && fcs_regen == $past(dec_fcs)
            && edit_action == $past(dec_action))
        else $error("edit instruction not delivered");

    chk_total_count: assert property (!count_clear && (buffer_drop[0] // R15
        || rate_drop[0])
        |=> total_q[0] == CNT_W'($past(total_q[0]) + 1'b1))
        else $error("port 0 total drop not counted");

    chk_rate_count: assert property (!count_clear && !rate_drop[1] // R16
        |=> rate_q[1] == $past(rate_q[1]))
        else $error("port 1 rate count moved without rate drop");

    chk_irq_pulse: assert property (rate_drop[2] && irq_mask[2] // R17
        |=> irq_sources[2] ##1 (irq_sources[2] == $past((rate_drop[2]
            | buffer_drop[2]) & irq_mask[2])))
        else $error("masked interrupt source wrong");

endmodule : egress_vlan_tag_editor

//--- design/egress_tag_cfg.svh
// constants for the egress vlan tag editor: field positions and resets
//
// How it works
// (R1) dumb egress port passes untagged, priority and normal frames untouched
// (R2) host special tag is stripped before leaving dumb, access or hybrid ports
// (R3) access port passes untagged frames and strips priority or normal tags
// (R4) frames leaving the cpu egress port carry the host special tag
// (R5) untag instruction is three per-port bits from a vlan table entry
// (R6) hybrid: untagged frame gets tag if insert set and default untag clear
// (R7) inserted tag takes ingress or egress defaults, chosen by select bit; select clear uses ingress_prio, not ingress default prio
// (R8) hybrid: priority tag stripped when default-vid untag bit is set
// (R9) else priority tag rewritten: vid always, priority if change-prio set
// (R10) hybrid: normal tag stripped when received-vid untag bit is set
// (R11) normal tag kept unchanged when change-tag bit is clear
// (R12) normal tag kept when change-vid and change-prio are both clear
// (R13) else rewrite vid if change-vid, priority if change-prio
// (R14) each port holds a configurable default vlan id and priority
// (R15) per ingress port count every buffer or rate drop
// (R16) per ingress port count rate-limit drops alone
// (R17) several maskable interrupt sources can be raised
// (R18) any inserted, removed or rewritten tag asks for a new fcs
`ifndef EGRESS_TAG_CFG_SVH
`define EGRESS_TAG_CFG_SVH

// -------------------------------------------------------------------
// per-port egress config field, seven bits per port
// -------------------------------------------------------------------
`define CFG_TYPE_LSB        0
`define CFG_INSERT_BIT      2
`define CFG_CHANGE_TAG_BIT  3
`define CFG_CHANGE_VID_BIT  4
`define CFG_CHANGE_PRIO_BIT 5
`define CFG_SELECT_BIT      6
`define CFG_PORT_W          7

// -------------------------------------------------------------------
// default vlan id and priority word
// -------------------------------------------------------------------
`define VID_W               12
`define PRIO_W              3
`define DEF_VID_LSB         0
`define DEF_PRIO_LSB        12
`define DEF_W               15

// -------------------------------------------------------------------
// reset values
// -------------------------------------------------------------------
`define IRQ_RESET           3'h0

`endif

//--- design/egress_tag_pkg.sv
// types shared by the egress vlan tag editor
package egress_tag_pkg;

    // egress port type, as coded in the config field
    typedef enum logic [1:0] {
        port_dumb,
        port_access,
        port_hybrid,
        port_cpu
    } port_type_t;

    // received frame classification
    typedef enum logic [1:0] {
        kind_untagged,
        kind_priority,
        kind_normal,
        kind_special
    } frame_kind_t;

    // edit applied to the outgoing frame
    typedef enum logic [2:0] {
        act_pass,
        act_insert,
        act_strip,
        act_rewrite,
        act_host_tag
    } tag_action_t;

endpackage : egress_tag_pkg

//--- design/edit_buffer.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module edit_buffer #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             reset_n,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    // -------------------------------------------------------------------
    // storage and pointers
    // -------------------------------------------------------------------
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    rd_q;
    logic [PW:0]      fill_q;
    logic             push;
    logic             pop;

    initial begin
        if (DEPTH < 2 || WIDTH < 1) begin
            $error("edit_buffer needs DEPTH >= 2 and WIDTH >= 1");
        end
    end

    // honest full and empty from the fill count
    assign in_ready  = (fill_q != (PW+1)'(DEPTH));
    assign out_valid = (fill_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // pointer wrap
    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction : bump

    // storage, not reset: out_valid masks stale words
    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // write side
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= '0;
        end else if (push) begin
            wr_q <= bump(wr_q);
        end
    end

    // read side
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_q <= '0;
        end else if (pop) begin
            rd_q <= bump(rd_q);
        end
    end

    // occupancy
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fill_q <= '0;
        end else if (push && !pop) begin
            fill_q <= fill_q + 1'b1;
        end else if (pop && !push) begin
            fill_q <= fill_q - 1'b1;
        end
    end

endmodule : edit_buffer

//--- sim/mac_model.sv
// transmit mac stand-in that takes edit instructions, sometimes late
`timescale 1ns/10ps
module mac_model (
    // clock and reset
    input  wire logic clock,
    input  wire logic reset_n,
    // stall control and handshake
    input  wire logic hold,
    output logic      edit_ready
);
    logic [1:0] cnt_q;

    // free-running phase, one cycle in four is a stall
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) cnt_q <= 2'h0;
        else cnt_q <= cnt_q + 2'h1;
    end
    assign edit_ready = !hold && cnt_q != 2'h1;
endmodule : mac_model

//--- sim/tb.sv
// self-checking bench for the egress vlan tag editor
`timescale 1ns/10ps
module tb;
    logic        clock, reset_n, frame_valid, frame_ready, edit_valid;
    logic        edit_ready, fcs_regen, count_clear, hold;
    logic [1:0]  frame_kind, ingress_port, egress_port, edit_port;
    logic [11:0] rx_vlan_identifier, edit_vlan_identifier;
    logic [2:0]  rx_prio, ingress_prio, untag_by_default, untag_by_rx;
    logic [2:0]  edit_action, edit_prio, buffer_drop, rate_drop;
    logic [2:0]  irq_mask, irq_sources;
    logic [20:0] egress_port_tag_config;
    logic [14:0] port0_default_vlan_prio, port1_default_vlan_prio;
    logic [14:0] port2_default_vlan_prio;
    logic [31:0] port0_total_drop_count, port1_total_drop_count;
    logic [31:0] port2_total_drop_count, port0_rate_drop_count;
    logic [31:0] port1_rate_drop_count, port2_rate_drop_count;
    int          fails, n_tests;

    egress_vlan_tag_editor DUT (.*);
    mac_model mac (.clock, .reset_n, .hold, .edit_ready);

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic test_done;
        if (fails == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // bounded wait: 0 descriptor taken, 1 instruction handed over
    task automatic await(input int which);
        for (int n = 0; n < 100; n++) begin
            @(negedge clock);
            if (which == 0 ? frame_ready : edit_valid && edit_ready) return;
        end
        fails++;
        test_done();
    endtask : await

    task automatic cfg(input logic [1:0] p, input logic [6:0] v);
        egress_port_tag_config[7*p +: 7] <= v;
    endtask : cfg

    task automatic send(input logic [1:0] k, ep, input logic [2:0] ua, ur,
                        act, input logic [11:0] vlan_identifier, input logic [2:0] pr);
        frame_kind <= k;
        egress_port <= ep;
        untag_by_default <= ua;
        untag_by_rx <= ur;
        frame_valid <= 1'b1;
        await(0);
        @(posedge clock);
        frame_valid <= 1'b0;
        await(1);
        chk(edit_action, act);
        chk(edit_port, ep);
        chk(fcs_regen, act != 3'h0);
        if (act == 3'h1 || act == 3'h3) begin
            chk(edit_vlan_identifier, vlan_identifier);
            chk(edit_prio, pr);
        end
        @(posedge clock);
    endtask : send

    task automatic t_dumb;
        cfg(1, 7'h7C);
        for (int k = 0; k < 3; k++) send(k, 1, 7, 7, 0, 0, 0);
        send(3, 1, 0, 0, 2, 0, 0);
    endtask : t_dumb

    task automatic t_access;
        cfg(1, 7'h01);
        for (int k = 0; k < 4; k++) send(k, 1, 0, 0, k ? 2 : 0, 0, 0);
    endtask : t_access

    task automatic t_cpu;
        cfg(0, 7'h03);
        send(0, 0, 0, 0, 4, 0, 0);
        send(3, 0, 0, 0, 0, 0, 0);
    endtask : t_cpu

    task automatic t_hybrid;
        cfg(2, 7'h06);
        send(0, 2, 0, 0, 1, 12'h123, 3'h7);
        cfg(2, 7'h46);
        send(0, 2, 0, 0, 1, 12'h789, 3'h6);
        send(0, 2, 3'h4, 0, 0, 0, 0);
        send(0, 2, 3'h3, 3'h4, 1, 12'h789, 3'h6);
        send(1, 2, 3'h4, 0, 2, 0, 0);
        cfg(2, 7'h02);
        send(1, 2, 0, 3'h4, 3, 12'h123, 3'h1);
        cfg(2, 7'h62);
        send(1, 2, 0, 0, 3, 12'h789, 3'h6);
        send(2, 2, 0, 3'h4, 2, 0, 0);
        cfg(2, 7'h72);
        send(2, 2, 3'h4, 0, 0, 0, 0);
        cfg(2, 7'h0A);
        send(2, 2, 0, 0, 0, 0, 0);
        cfg(2, 7'h1A);
        send(2, 2, 0, 0, 3, 12'h123, 3'h1);
        cfg(2, 7'h6A);
        send(2, 2, 0, 0, 3, 12'hABC, 3'h6);
        send(3, 2, 0, 0, 2, 0, 0);
    endtask : t_hybrid

    // fill the buffer while the mac stalls, then drain it in order
    task automatic t_fill;
        hold <= 1'b1;
        frame_kind <= 2'h0;
        frame_valid <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            egress_port <= i[1:0];
            await(0);
            @(posedge clock);
        end
        egress_port <= 2'h2;
        @(negedge clock);
        chk(frame_ready, 1'b0);
        @(posedge clock);
        hold <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            await(1);
            chk(edit_port, i);
            @(posedge clock);
            if (i == 0) begin
                hold <= 1'b1;
                await(0);
                @(posedge clock);
                frame_valid <= 1'b0;
                hold <= 1'b0;
            end
        end
        @(negedge clock);
        chk(edit_valid, 1'b0);
    endtask : t_fill

    task automatic t_count;
        @(posedge clock);
        irq_mask <= 3'h2;
        rate_drop <= 3'h1;
        buffer_drop <= 3'h2;
        @(posedge clock);
        rate_drop <= 3'h0;
        buffer_drop <= 3'h0;
        @(negedge clock);
        chk(irq_sources, 3'h2);
        chk(port0_total_drop_count, 32'h0000_0001);
        chk(port0_rate_drop_count, 32'h0000_0001);
        chk(port1_total_drop_count, 32'h0000_0001);
        chk(port1_rate_drop_count, 32'h0000_0000);
        @(posedge clock);
        count_clear <= 1'b1;
        rate_drop <= 3'h4;
        @(posedge clock);
        count_clear <= 1'b0;
        rate_drop <= 3'h0;
        @(negedge clock);
        chk(port0_total_drop_count, 32'h0000_0000);
        chk(port2_total_drop_count, 32'h0000_0001);
        chk(port2_rate_drop_count, 32'h0000_0001);
        chk(irq_sources, 3'h0);
    endtask : t_count

    initial begin
        {reset_n, frame_valid, count_clear, hold, frame_kind} = '0;
        {ingress_port, egress_port, untag_by_default, untag_by_rx} = '0;
        {buffer_drop, rate_drop, irq_mask, egress_port_tag_config} = '0;
        rx_vlan_identifier = 12'hABC;
        rx_prio = 3'h1;
        ingress_prio = 3'h7;
        port0_default_vlan_prio = 15'h5123;
        port1_default_vlan_prio = 15'h2456;
        port2_default_vlan_prio = 15'h6789;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        t_dumb();
        t_access();
        t_cpu();
        t_hybrid();
        t_fill();
        t_count();
        test_done();
    end
endmodule : tb
